// File: verilog/sbw_pkg.sv
// shared constants, state type and lane helpers for the burst write masking block
// Overview of operation
// R01: 8-bit word, both nibble selects low: store all eight data bits.
// R02: 8-bit word, low select only: write bits 3..0, keep bits 7..4.
// R03: 8-bit word, high select only: write bits 7..4, keep bits 3..0.
// R04: 18-bit word, lane 0 only: write bits 8..0, keep bits 17..9.
// R05: 18-bit word, lane 1 only: write bits 17..9, keep bits 8..0.
// R06: 8/18-bit word, both selects high: the addressed word stays unmodified.
// R07: 36-bit word, all four lane selects low: write all 36 bits.
// R08: 36-bit word, lane 0 only: write bits 8..0, keep 35..9.
// R09: 36-bit word, lane 1 only: write bits 17..9, keep the rest.
// R10: 36-bit word, lane 2 only: write bits 26..18, keep the rest.
// R11: 36-bit word, lane 3 only: write bits 35..27, keep 26..0.
// R12: 36-bit word, all lane selects high: no array update that beat.
// R13: selects may change between beats; each beat uses its own selects.
// R14: controller starts write with load and read/write low, then two beats.
// R15: first beat mask goes to first burst word, second to second.
package sbw_pkg;

  localparam int ORG_X8        = 8;
  localparam int ORG_X18       = 18;
  localparam int ORG_X36       = 36;
  localparam int NIBBLE_W      = 4;
  localparam int BYTE_W        = 9;
  localparam int LANES_NARROW  = 2;
  localparam int LANES_WIDE    = 4;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SYNC_STAGES   = 2;
  localparam int DEF_ADDR_W    = 4;
  localparam logic RST_LOAD_N  = 1'b1;
  localparam logic RST_RW_SEL  = 1'b1;
  localparam logic RST_SEL_N   = 1'b1;

  typedef enum logic [1:0] {
    SBW_IDLE,
    SBW_BEAT0,
    SBW_BEAT1
  } sbw_state_t;

  function automatic int sbw_lanes(input int width);
    return (width == ORG_X36) ? LANES_WIDE : LANES_NARROW;
  endfunction

  function automatic int sbw_lane_w(input int width);
    return (width == ORG_X8) ? NIBBLE_W : BYTE_W;
  endfunction

endpackage

// File: verilog/sbw_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sbw_sync #(
  parameter int         W       = 1,
  parameter logic [0:0] RST_VAL = 1'b0
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_reg <= {W{RST_VAL}};
      o_sync   <= {W{RST_VAL}};
    end
    else
    begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule

// File: verilog/sbw_lane_mask.sv
// expands active-low lane selects into a per-bit write mask
`timescale 1ns/1ps
module sbw_lane_mask #(
  parameter int DATA_W = 36,
  parameter int LANES  = 4,
  parameter int LANE_W = 9
) (
  input  wire logic [LANES-1:0]  i_sel_n,
  output logic      [DATA_W-1:0] o_mask
);

  genvar b;
  generate
    for (b = 0; b < DATA_W; b++)
    begin : g_bit
      assign o_mask[b] = ~i_sel_n[b / LANE_W];
    end
  endgenerate

endmodule

// File: verilog/sbw_write_port.sv
// burst-of-two write port with per-beat lane masking into the word array
`timescale 1ns/1ps
module sbw_write_port #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = sbw_pkg::DEF_ADDR_W
) (
  input  wire logic                                i_ref_clk,
  input  wire logic                                i_rst,
  input  wire logic                                i_load_strobe_n,
  input  wire logic                                i_read_write_sel,
  input  wire logic [ADDR_W-1:0]                   i_addr,
  input  wire logic [DATA_W-1:0]                   i_wr_data,
  input  wire logic [sbw_pkg::sbw_lanes(DATA_W)-1:0] i_lane_write_select_n,
  input  wire logic [ADDR_W-1:0]                   i_rd_addr,
  output logic      [DATA_W-1:0]                   o_rd_data,
  output logic                                     o_write_busy,
  output logic                                     o_word_written
);

  localparam int LANES  = sbw_pkg::sbw_lanes(DATA_W);
  localparam int LANE_W = sbw_pkg::sbw_lane_w(DATA_W);
  localparam int DEPTH  = 1 << ADDR_W;

  // in the 8-bit organisation bit 0 is nibble_select_low, bit 1 nibble_select_high
  logic [LANES-1:0]   s_sel_n;
  logic [DATA_W-1:0]  s_data;
  logic [ADDR_W-1:0]  s_addr;
  logic               s_load_n;
  logic               s_rw_sel;

  sbw_pkg::sbw_state_t state_reg;
  sbw_pkg::sbw_state_t state_next;

  logic [ADDR_W-1:0]  base_addr_reg;
  logic [ADDR_W-1:0]  first_addr;
  logic [ADDR_W-1:0]  wr_addr;
  logic [DATA_W-1:0]  wr_mask;
  logic [DATA_W-1:0]  cur_word;
  logic               in_beat;
  logic               wr_en;
  logic               start;
  logic               written_reg;
  logic [DATA_W-1:0]  rd_data_reg;
  logic [DATA_W-1:0]  mem [DEPTH];

  // every write pin group goes through two flops, so beats and command stay aligned
  sbw_sync #(
    .W       (LANES),
    .RST_VAL (sbw_pkg::RST_SEL_N)
  ) u_sync_sel (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   (i_lane_write_select_n),
    .o_sync    (s_sel_n)
  );

  sbw_sync #(
    .W       (DATA_W),
    .RST_VAL (1'b0)
  ) u_sync_data (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   (i_wr_data),
    .o_sync    (s_data)
  );

  sbw_sync #(
    .W       (ADDR_W),
    .RST_VAL (1'b0)
  ) u_sync_addr (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   (i_addr),
    .o_sync    (s_addr)
  );

  sbw_sync #(
    .W       (1),
    .RST_VAL (sbw_pkg::RST_LOAD_N)
  ) u_sync_load (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   (i_load_strobe_n),
    .o_sync    (s_load_n)
  );

  sbw_sync #(
    .W       (1),
    .RST_VAL (sbw_pkg::RST_RW_SEL)
  ) u_sync_rw (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   (i_read_write_sel),
    .o_sync    (s_rw_sel)
  );

  // R14 write start decode
  assign start = ~s_load_n & ~s_rw_sel;

  // a command is not taken while the first beat is in flight
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      sbw_pkg::SBW_IDLE:
        if (start)
          state_next = sbw_pkg::SBW_BEAT0;
      sbw_pkg::SBW_BEAT0:
        state_next = sbw_pkg::SBW_BEAT1;
      sbw_pkg::SBW_BEAT1:
        state_next = start ? sbw_pkg::SBW_BEAT0 : sbw_pkg::SBW_IDLE;
      default:
        state_next = sbw_pkg::SBW_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      state_reg <= sbw_pkg::SBW_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      base_addr_reg <= '0;
    else if (start && state_reg != sbw_pkg::SBW_BEAT0)
      base_addr_reg <= s_addr;
  end

  // R15 burst word order
  generate
    if (DATA_W == sbw_pkg::ORG_X8)
    begin : g_addr_x8
      // narrow burst always starts at the even word
      assign first_addr = {base_addr_reg[ADDR_W-1:1], 1'b0};
    end
    else
    begin : g_addr_wide
      assign first_addr = base_addr_reg;
    end
  endgenerate

  assign wr_addr = (state_reg == sbw_pkg::SBW_BEAT0) ? first_addr
                                                     : (first_addr ^ ADDR_W'(1));
  assign in_beat = (state_reg == sbw_pkg::SBW_BEAT0) || (state_reg == sbw_pkg::SBW_BEAT1);

  // R13 selects of this beat only
  sbw_lane_mask #(
    .DATA_W (DATA_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_mask (
    .i_sel_n (s_sel_n),
    .o_mask  (wr_mask)
  );

  // R06 R12 all selects high skip update
  assign wr_en    = in_beat && (|wr_mask);
  assign cur_word = mem[wr_addr];

  // R01 R02 R03 R04 R05 R07 R08 R09 R10 R11 merge under mask
  // no reset on the array: words read unknown until first written
  always_ff @(posedge i_ref_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= (cur_word & ~wr_mask) | (s_data & wr_mask);
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      written_reg <= 1'b0;
    else
      written_reg <= wr_en;
  end

  // readback is a same-clock port, so no synchroniser in front of it
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      rd_data_reg <= '0;
    else
      rd_data_reg <= mem[i_rd_addr];
  end

  assign o_rd_data      = rd_data_reg;
  assign o_word_written = written_reg;
  assign o_write_busy   = in_beat;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  property p_lane(logic [LANES-1:0] sel, logic [DATA_W-1:0] m);
    (in_beat && s_sel_n == sel) |=>
      mem[$past(wr_addr)] == (($past(cur_word) & ~m) | ($past(s_data) & m));
  endproperty

  generate
    if (DATA_W == sbw_pkg::ORG_X8)
    begin : g_chk_x8
      chk_nib_both: assert property (p_lane(2'b00, 8'hff)) // R01
        else $error("both nibbles not written");
      chk_nib_low: assert property (p_lane(2'b10, 8'h0f)) // R02
        else $error("low nibble write wrong");
      chk_nib_high: assert property (p_lane(2'b01, 8'hf0)) // R03
        else $error("high nibble write wrong");
      chk_nib_none: assert property (p_lane(2'b11, 8'h00)) // R06
        else $error("word changed with no select");
      // R15 narrow burst starts even
      chk_nib_even: assert property ( // R15
        (state_reg == sbw_pkg::SBW_BEAT0) |-> !wr_addr[0])
        else $error("narrow burst did not start on even word");
    end
    else if (DATA_W == sbw_pkg::ORG_X18)
    begin : g_chk_x18
      chk_byte_low: assert property (p_lane(2'b10, 18'h001ff)) // R04
        else $error("lower byte write wrong");
      chk_byte_high: assert property (p_lane(2'b01, 18'h3fe00)) // R05
        else $error("upper byte write wrong");
      chk_byte_none: assert property (p_lane(2'b11, 18'h00000)) // R06
        else $error("word changed with no select");
    end
    else
    begin : g_chk_x36
      chk_lane_all: assert property (p_lane(4'b0000, 36'hfffffffff)) // R07
        else $error("full word not written");
      chk_lane_zero: assert property (p_lane(4'b1110, 36'h0000001ff)) // R08
        else $error("lane 0 write wrong");
      chk_lane_one: assert property (p_lane(4'b1101, 36'h00003fe00)) // R09
        else $error("lane 1 write wrong");
      chk_lane_two: assert property (p_lane(4'b1011, 36'h007fc0000)) // R10
        else $error("lane 2 write wrong");
      chk_lane_three: assert property (p_lane(4'b0111, 36'hff8000000)) // R11
        else $error("lane 3 write wrong");
      chk_lane_none: assert property (p_lane(4'b1111, 36'h000000000)) // R12
        else $error("word changed with no select");
    end
  endgenerate

  chk_start_beats: assert property ( // R14
    (state_reg == sbw_pkg::SBW_IDLE && start) |=>
      state_reg == sbw_pkg::SBW_BEAT0 ##1 state_reg == sbw_pkg::SBW_BEAT1)
    else $error("write beats did not follow start");

  chk_second_word: assert property ( // R15
    (state_reg == sbw_pkg::SBW_BEAT0) |=>
      in_beat && wr_addr == ($past(wr_addr) ^ ADDR_W'(1)))
    else $error("second beat not on partner word");

  chk_beat_own_sel: assert property ( // R13
    (state_reg == sbw_pkg::SBW_BEAT1 && s_sel_n != $past(s_sel_n)) |->
      wr_en == (s_sel_n != {LANES{1'b1}}))
    else $error("second beat used stale selects");

  chk_written_flag: assert property (
    wr_en |=> o_word_written)
    else $error("write pulse missing");

  // R06 R12 no pulse when masked
  chk_written_none: assert property ( // R06 R12
    (in_beat && s_sel_n == {LANES{1'b1}}) |=> !o_word_written)
    else $error("write pulse with all lanes masked");

  // R14 reads never open a burst
  chk_read_ignored: assert property ( // R14
    (state_reg == sbw_pkg::SBW_IDLE && !s_load_n && s_rw_sel) |=>
      state_reg == sbw_pkg::SBW_IDLE)
    else $error("read command started a write");

  // R14 busy only after a start
  chk_busy_source: assert property ( // R14
    $rose(o_write_busy) |-> $past(start) && state_reg == sbw_pkg::SBW_BEAT0)
    else $error("busy rose without a write command");

  // R14 single burst then idle
  chk_idle_after_pair: assert property ( // R14
    (state_reg == sbw_pkg::SBW_BEAT1 && !start) |=> !o_write_busy)
    else $error("busy held past the second beat");

  // R15 start word held in burst
  // a new command may land in the second beat, so only the first beat is guarded
  chk_addr_held: assert property ( // R15
    (state_reg == sbw_pkg::SBW_BEAT0) |=> $stable(base_addr_reg))
    else $error("burst start word moved mid burst");

  cov_full_write: cover property (in_beat && s_sel_n == {LANES{1'b0}});
  cov_masked_write: cover property (in_beat && s_sel_n != {LANES{1'b0}} && wr_en);
  cov_sel_change: cover property (
    state_reg == sbw_pkg::SBW_BEAT0 ##1 s_sel_n != $past(s_sel_n));
  cov_back_to_back: cover property (state_reg == sbw_pkg::SBW_BEAT1 && start);
  cov_read_cmd: cover property (state_reg == sbw_pkg::SBW_IDLE && !s_load_n && s_rw_sel);

endmodule

// File: testbench/sbw_ctrl_model.sv
// behavioural memory controller driving the burst write pins
`timescale 1ns/1ps
module sbw_ctrl_model #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 4,
  parameter int LANES  = 4
) (
  input  wire logic              i_ref_clk,
  output logic                   o_load_strobe_n,
  output logic                   o_read_write_sel,
  output logic [ADDR_W-1:0]      o_addr,
  output logic [DATA_W-1:0]      o_wr_data,
  output logic [LANES-1:0]       o_lane_write_select_n
);
  initial
  begin
    o_load_strobe_n = 1'b1;
    o_read_write_sel = 1'b1;
    o_addr = '0;
    o_wr_data = '0;
    o_lane_write_select_n = '1;
  end

  task automatic burst(input logic rw, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d0, input logic [LANES-1:0] s0,
                       input logic [DATA_W-1:0] d1, input logic [LANES-1:0] s1);
    @(negedge i_ref_clk);
    o_load_strobe_n = 1'b0;
    o_read_write_sel = rw;
    o_addr = a;
    @(negedge i_ref_clk);
    o_load_strobe_n = 1'b1;
    o_read_write_sel = 1'b1;
    o_addr = ~a;
    o_wr_data = d0;
    o_lane_write_select_n = s0;
    @(negedge i_ref_clk);
    o_wr_data = d1;
    o_lane_write_select_n = s1;
    @(negedge i_ref_clk);
    // released bus shows inverse, never a stale copy
    o_wr_data = ~d1;
    o_lane_write_select_n = '1;
  endtask
endmodule

// File: testbench/sbw_byte_write_mask_tb.sv
// self-checking bench for the burst write port in all three word organisations
`timescale 1ns/1ps
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, act, exp); end end
module sbw_byte_write_mask_tb;
  localparam int DW = 36;
  localparam int AW = 4;
  localparam int LN = 4;
  logic          i_ref_clk;
  logic          i_rst;
  logic          ld_n;
  logic          rw;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [LN-1:0] sel_n;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  logic          busy;
  logic [7:0]    rd8;
  logic [17:0]   rd18;
  logic          wr36;
  logic          wr8;
  logic          wr18;
  logic [DW-1:0] exp_mem [16];
  logic [DW-1:0] exp_n [16];
  logic [DW-1:0] exp_b [16];
  logic [LN-1:0] tbl [5] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hf};
  int            error_cnt = 0;
  int            comparisons = 0;
  int            cyc = 0;

  sbw_write_port #(.DATA_W(DW), .ADDR_W(AW)) u_dut (
    .i_ref_clk             (i_ref_clk),
    .i_rst                 (i_rst),
    .i_load_strobe_n       (ld_n),
    .i_read_write_sel      (rw),
    .i_addr                (addr),
    .i_wr_data             (wdata),
    .i_lane_write_select_n (sel_n),
    .i_rd_addr             (rd_addr),
    .o_rd_data             (rd_data),
    .o_write_busy          (busy),
    .o_word_written        (wr36)
  );

  // narrow organisations share the pins, on the low data bits and two selects
  sbw_write_port #(.DATA_W(sbw_pkg::ORG_X8), .ADDR_W(AW)) u_dut_x8 (
    .i_ref_clk             (i_ref_clk),
    .i_rst                 (i_rst),
    .i_load_strobe_n       (ld_n),
    .i_read_write_sel      (rw),
    .i_addr                (addr),
    .i_wr_data             (wdata[7:0]),
    .i_lane_write_select_n (sel_n[1:0]),
    .i_rd_addr             (rd_addr),
    .o_rd_data             (rd8),
    .o_write_busy          (),
    .o_word_written        (wr8)
  );

  sbw_write_port #(.DATA_W(sbw_pkg::ORG_X18), .ADDR_W(AW)) u_dut_x18 (
    .i_ref_clk             (i_ref_clk),
    .i_rst                 (i_rst),
    .i_load_strobe_n       (ld_n),
    .i_read_write_sel      (rw),
    .i_addr                (addr),
    .i_wr_data             (wdata[17:0]),
    .i_lane_write_select_n (sel_n[1:0]),
    .i_rd_addr             (rd_addr),
    .o_rd_data             (rd18),
    .o_write_busy          (),
    .o_word_written        (wr18)
  );

  sbw_ctrl_model #(.DATA_W(DW), .ADDR_W(AW), .LANES(LN)) u_ctrl (
    .i_ref_clk             (i_ref_clk),
    .o_load_strobe_n       (ld_n),
    .o_read_write_sel      (rw),
    .o_addr                (addr),
    .o_wr_data             (wdata),
    .o_lane_write_select_n (sel_n)
  );

  initial
  begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] d,
                                           input logic [LN-1:0] s, input int lw, input int w);
    logic [DW-1:0] r;
    r = old;
    for (int b = 0; b < w; b++)
      if (!s[b / lw]) r[b] = d[b];
    return r;
  endfunction

  // beats with at least one lane low, each gives one written pulse
  function automatic int n_upd(input logic [LN-1:0] s0, input logic [LN-1:0] s1, input int ln);
    logic [LN-1:0] m;
    m = LN'((1 << ln) - 1);
    return int'((s0 & m) != m) + int'((s1 & m) != m);
  endfunction

  task automatic close_out();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_word(input logic [AW-1:0] a);
    @(negedge i_ref_clk);
    rd_addr = a;
    repeat (2) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    `CHK(rd_data, exp_mem[a])
    `CHK(rd18, exp_b[a][17:0])
    `CHK(rd8, exp_n[a][7:0])
  endtask

  task automatic op(input logic r, input logic [AW-1:0] a, input logic [LN-1:0] s0,
                    input logic [LN-1:0] s1);
    logic [DW-1:0] d0;
    logic [DW-1:0] d1;
    logic [AW-1:0] f;
    logic          seen;
    int            n;
    int            c36;
    int            c8;
    int            c18;
    d0 = DW'({$urandom, $urandom});
    d1 = DW'({$urandom, $urandom});
    f = {a[AW-1:1], 1'b0};
    seen = 1'b0;
    n = 0;
    c36 = 0;
    c8 = 0;
    c18 = 0;
    u_ctrl.burst(r, a, d0, s0, d1, s1);
    while (n < 12)
    begin
      if (busy === 1'b1) seen = 1'b1;
      if (wr36 === 1'b1) c36++;
      if (wr8 === 1'b1) c8++;
      if (wr18 === 1'b1) c18++;
      @(negedge i_ref_clk);
      n++;
    end
    `CHK(seen, !r)
    `CHK(c36, r ? 0 : n_upd(s0, s1, LN))
    `CHK(c18, r ? 0 : n_upd(s0, s1, sbw_pkg::LANES_NARROW))
    `CHK(c8, r ? 0 : n_upd(s0, s1, sbw_pkg::LANES_NARROW))
    if (!r)
    begin
      // burst partner is the other word of the pair
      exp_mem[a] = merge(exp_mem[a], d0, s0, sbw_pkg::BYTE_W, DW);
      exp_mem[a ^ 1] = merge(exp_mem[a ^ 1], d1, s1, sbw_pkg::BYTE_W, DW);
      exp_b[a] = merge(exp_b[a], d0, s0, sbw_pkg::BYTE_W, sbw_pkg::ORG_X18);
      exp_b[a ^ 1] = merge(exp_b[a ^ 1], d1, s1, sbw_pkg::BYTE_W, sbw_pkg::ORG_X18);
      // narrow burst always opens on the even word
      exp_n[f] = merge(exp_n[f], d0, s0, sbw_pkg::NIBBLE_W, sbw_pkg::ORG_X8);
      exp_n[f ^ 1] = merge(exp_n[f ^ 1], d1, s1, sbw_pkg::NIBBLE_W, sbw_pkg::ORG_X8);
    end
    chk_word(a);
    chk_word(a ^ 1);
  endtask

  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      close_out();
    end
  end

  initial
  begin
    i_rst = 1'b1;
    rd_addr = '0;
    void'($urandom(85));
    repeat (6) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst = 1'b0;
    // memory powers up unknown, so fill every pair whole
    for (int a = 0; a < 16; a += 2)
      op(1'b0, a[AW-1:0], 4'h0, 4'h0);
    // each single lane and all-high, odd start, beats differ
    for (int i = 0; i < 5; i++)
      op(1'b0, AW'(2 * i + 1), tbl[i], tbl[(i + 1) % 5]);
    op(1'b0, 4'h4, 4'hf, 4'h0);
    // read command must leave the array alone
    op(1'b1, 4'h6, 4'h0, 4'h0);
    for (int i = 0; i < 40; i++)
      op(1'b0, AW'($urandom), LN'($urandom), LN'($urandom));
    close_out();
  end
endmodule
